/* logic/dac_link_pkg.sv */
/*
  shared constants for the dual converter serial front end: word layout,
  channel address codes, reset and clear codes, timing counts, register map.
  assumes a 250 MHz core clock and a 32-bit AHB-Lite register bus.
*/
package dac_link_pkg;
    localparam int          WORD_BITS       = 24;
    localparam int          CODE_BITS       = 16;
    localparam int          CHANNELS        = 2;
    localparam int          PIN_COUNT       = 6;
    localparam logic [4:0]  WORD_BITS_CNT   = 5'h18;

    // command word layout
    localparam int          CMD_READ_BIT    = 23;
    localparam int          CMD_ADDR_HI     = 18;
    localparam int          CMD_ADDR_LO     = 16;
    localparam logic [2:0]  ADDR_CHAN_ALL   = 3'h4;

    localparam logic [15:0] DAC_RESET_CODE  = 16'h0000;
    localparam logic [15:0] ZERO_SCALE_TAP  = 16'h0000;
    localparam logic [15:0] MID_SCALE_TAP   = 16'h8000;
    localparam logic [15:0] CODE_MSB_MASK   = 16'h8000;

    // link timing
    localparam int          CORE_CLK_MHZ    = 250;
    localparam int          LINK_MAX_MHZ    = 30;
    localparam int          LINK_MIN_FALL_CYC = CORE_CLK_MHZ / LINK_MAX_MHZ;

    // pins idle high after reset so no false edge appears
    localparam logic [5:0]  PIN_IDLE        = 6'h3f;

    // register byte offsets
    localparam logic [7:0]  OFF_CTRL        = 8'h00;
    localparam logic [7:0]  OFF_STATUS      = 8'h04;
    localparam logic [7:0]  OFF_DAC_A       = 8'h08;
    localparam logic [7:0]  OFF_DAC_B       = 8'h0c;
    localparam logic [7:0]  OFF_IN_A        = 8'h10;
    localparam logic [7:0]  OFF_IN_B        = 8'h14;
    localparam logic [7:0]  OFF_LAST_CMD    = 8'h18;

    // control fields
    localparam int          CTRL_BIPOLAR_LO = 0;
    localparam int          CTRL_CLEAR_MID  = 2;
    localparam int          CTRL_SDO_EN     = 3;
    localparam int          CTRL_BITS       = 4;
    localparam logic [3:0]  CTRL_RESET      = 4'h0;

    // status fields
    localparam int          STAT_OVERSPEED  = 0;
    localparam int          STAT_FRAME      = 1;
    localparam int          STAT_LOAD_LVL   = 2;
    localparam int          STAT_CLEAR      = 3;
    localparam int          STAT_CODING     = 4;

    localparam logic [1:0]  HTRANS_NONSEQ   = 2'h2;
    localparam logic        HRESP_OKAY      = 1'b0;
endpackage

/* logic/pin_sync.sv */
/*
  two-flop synchroniser for a group of pins from outside the core clock.
  assumes each pin is a slow level or a clock well below the core rate.
*/
`timescale 1ns/1ps
module pin_sync #(
    parameter int               WIDTH     = 6,
    parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
    input  wire logic             core_clk,
    input  wire logic             rst_b,
    input  wire logic [WIDTH-1:0] pinIn,
    output logic      [WIDTH-1:0] pinSync
);
    logic [WIDTH-1:0] stage1_q;

    // first stage feeds only the second stage
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            stage1_q <= RESET_VAL;
            pinSync  <= RESET_VAL;
        end
        else
        begin
            stage1_q <= pinIn;
            pinSync  <= stage1_q;
        end
    end
endmodule // pin_sync

/* logic/dac_code_map.sv */
/*
  maps a converter register code to the straight-binary tap code of the
  string. assumes range and coding levels are static while codes change.
*/
`timescale 1ns/1ps
module dac_code_map
    import dac_link_pkg::*;
(
    input  wire logic [CODE_BITS-1:0] regCode,
    input  wire logic                 bipolar,
    input  wire logic                 offsetBinary,
    output logic      [CODE_BITS-1:0] tapCode
);
    always_comb
    begin
        if (bipolar && !offsetBinary)
            tapCode = regCode ^ CODE_MSB_MASK;
        else
            tapCode = regCode;
    end
endmodule // dac_code_map

/* logic/dac_link_core.sv */
/*
  serial front end of a dual voltage-output converter: three-wire link
  sampled by the core clock, input and converter registers, load strobe,
  clear, code mapping and an AHB-Lite register slave.
  assumes link pins arrive asynchronously and the link runs at most 30 MHz.
*/
// Decided for this implementation: the AHB-Lite interface to the registers and the placing of the registers.
// What this block does
// - frame select low: one bit per falling edge
// - falling shift clock shifts data into register
// - shift clock at most 30 MHz; faster falling edges still shift and set the overspeed status bit
// - word acted on at frame select rising
// - load strobe low: update converter at frame end
// - load strobe high: only input register updated
// - load strobe falling edge copies pending inputs
// - one load falling edge updates both channels
// - clear forces zero-scale or midscale code
// - serial register shifted out on data output
// - data output changes on rising shift clock
// - bipolar, coding high: offset binary
// - bipolar, coding low: twos complement
// - unipolar: always straight binary
// - one frame carries one 24-bit word
// - reset sets converter registers to zero
`timescale 1ns/1ps
module dac_link_core
    import dac_link_pkg::*;
(
    input  wire logic                 core_clk,
    input  wire logic                 rst_b,
    input  wire logic                 serialClk,
    input  wire logic                 frameSel_n,
    input  wire logic                 serial_data_in,
    input  wire logic                 load_strobe_n,
    input  wire logic                 async_clear_n,
    input  wire logic                 coding_select,
    output logic                      serial_data_out,
    output logic      [CODE_BITS-1:0] analog_output_first,
    output logic      [CODE_BITS-1:0] analog_output_second,
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic                      hreadyout,
    output logic                      hresp,
    output logic      [31:0]          hrdata
);
    localparam logic [3:0] MIN_GAP_CNT = 4'(LINK_MIN_FALL_CYC - 1);

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);

    logic [PIN_COUNT-1:0]  pinSync;
    logic                  sclkS;
    logic                  frameS_n;
    logic                  sdiS;
    logic                  loadS_n;
    logic                  clearS_n;
    logic                  codingS;
    logic                  sclkPrev_q;
    logic                  framePrev_q;
    logic                  loadPrev_q;
    logic                  sclkFall;
    logic                  sclkRise;
    logic                  frameLow;
    logic                  frameStart;
    logic                  frameEnd;
    logic                  loadFall;
    logic                  shiftIn;
    logic                  clearLvl;
    logic [WORD_BITS-1:0]  shift_q;
    logic [4:0]            bitCnt_q;
    logic                  wordOk;
    logic                  isRead;
    logic [2:0]            cmdAddr;
    logic [CODE_BITS-1:0]  cmdData;
    logic                  writeEnd;
    logic [CODE_BITS-1:0]  readData;
    logic [WORD_BITS-1:0]  lastCmd_q;
    logic                  sdo_q;
    logic [3:0]            spacing_q;
    logic                  overspeed_q;
    logic                  overSet;
    logic [CTRL_BITS-1:0]  ctrl_q;
    logic                  sdoEn;
    logic [CHANNELS-1:0]   hit;
    logic [CHANNELS-1:0]   bipolar;
    logic [CODE_BITS-1:0]  inReg_q   [CHANNELS];
    logic [CODE_BITS-1:0]  dac_q     [CHANNELS];
    logic [CODE_BITS-1:0]  tapD      [CHANNELS];
    logic [CODE_BITS-1:0]  tap_q     [CHANNELS];
    logic [CODE_BITS-1:0]  clearCode [CHANNELS];
    logic                  apValid;
    logic                  wrPend_q;
    logic [7:0]            wrAddr_q;
    logic [31:0]           rdMux;
    logic [31:0]           rdata_q;

    // every link pin is asynchronous to the core clock
    pin_sync #(
        .WIDTH     (PIN_COUNT),
        .RESET_VAL (PIN_IDLE)
    ) u_pinSync (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .pinIn    ({coding_select, async_clear_n, load_strobe_n, serial_data_in, frameSel_n, serialClk}),
        .pinSync  (pinSync)
    );

    assign sclkS    = pinSync[0];
    assign frameS_n = pinSync[1];
    assign sdiS     = pinSync[2];
    assign loadS_n  = pinSync[3];
    assign clearS_n = pinSync[4];
    assign codingS  = pinSync[5];

    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            sclkPrev_q  <= 1'b1;
            framePrev_q <= 1'b1;
            loadPrev_q  <= 1'b1;
        end
        else
        begin
            sclkPrev_q  <= sclkS;
            framePrev_q <= frameS_n;
            loadPrev_q  <= loadS_n;
        end
    end

    assign sclkFall   = sclkPrev_q & ~sclkS;
    assign sclkRise   = ~sclkPrev_q & sclkS;
    assign frameLow   = ~frameS_n;
    assign frameStart = framePrev_q & ~frameS_n;
    assign frameEnd   = ~framePrev_q & frameS_n;
    assign loadFall   = loadPrev_q & ~loadS_n;
    assign shiftIn    = sclkFall & frameLow;
    assign clearLvl   = ~clearS_n;

    // shift register keeps only the newest 24 bits of a long frame
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            shift_q <= '0;
        else if (frameEnd && wordOk && isRead)
            shift_q <= {{(WORD_BITS-CODE_BITS){1'b0}}, readData};
        else if (shiftIn)
            shift_q <= {shift_q[WORD_BITS-2:0], sdiS};
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            bitCnt_q <= '0;
        else if (frameStart)
            bitCnt_q <= '0;
        else if (shiftIn && bitCnt_q != WORD_BITS_CNT)
            bitCnt_q <= bitCnt_q + 5'h01;
    end

    // short frames are dropped whole
    assign wordOk   = (bitCnt_q == WORD_BITS_CNT);
    assign isRead   = shift_q[CMD_READ_BIT];
    assign cmdAddr  = shift_q[CMD_ADDR_HI:CMD_ADDR_LO];
    assign cmdData  = shift_q[CODE_BITS-1:0];
    assign writeEnd = frameEnd & wordOk & ~isRead;
    assign readData = (cmdAddr == 3'h1) ? inReg_q[1] : inReg_q[0];

    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            lastCmd_q <= '0;
        else if (frameEnd && wordOk)
            lastCmd_q <= shift_q;
    end

    property p_shiftBit;
        shiftIn |=> shift_q == {$past(shift_q[WORD_BITS-2:0]), $past(sdiS)};
    endproperty
    a_shiftBit: assert property (p_shiftBit) else $error("bit not shifted on falling clock");

    property p_idleNoShift;
        (sclkFall && !frameLow && !frameEnd) |=> $stable(shift_q);
    endproperty
    a_idleNoShift: assert property (p_idleNoShift) else $error("shift outside a frame");

    // data out: first bit at frame start, then one per rising edge
    assign sdoEn = ctrl_q[CTRL_SDO_EN];

    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            sdo_q <= 1'b0;
        else if (!sdoEn)
            sdo_q <= 1'b0;
        else if (frameStart || (sclkRise && frameLow))
            sdo_q <= shift_q[WORD_BITS-1];
    end

    assign serial_data_out = sdo_q;

    property p_sdoOnRise;
        $changed(sdo_q) |-> $past(frameStart || (sclkRise && frameLow) || !sdoEn);
    endproperty
    a_sdoOnRise: assert property (p_sdoOnRise) else $error("data out moved off a rising edge");

    property p_sdoData;
        (sclkRise && frameLow && sdoEn) |=> sdo_q == $past(shift_q[WORD_BITS-1]);
    endproperty
    a_sdoData: assert property (p_sdoData) else $error("data out not the serial register msb");

    // spacing is only a warning; the quantised edges still shift correctly
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            spacing_q <= '1;
        else if (shiftIn)
            spacing_q <= '0;
        else if (spacing_q != 4'hf)
            spacing_q <= spacing_q + 4'h1;
    end

    assign overSet = shiftIn && (bitCnt_q != 5'h00) && (spacing_q < MIN_GAP_CNT);

    // set wins over a clear in the same cycle
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            overspeed_q <= 1'b0;
        else if (overSet)
            overspeed_q <= 1'b1;
        else if (wrPend_q && wrAddr_q == OFF_STATUS && hwdata[STAT_OVERSPEED])
            overspeed_q <= 1'b0;
    end

    genvar g;
    generate
        for (g = 0; g < CHANNELS; g++)
        begin : g_chan
            assign hit[g]       = (cmdAddr == ADDR_CHAN_ALL) || (cmdAddr == 3'(g));
            assign bipolar[g]   = ctrl_q[CTRL_BIPOLAR_LO + g];
            assign clearCode[g] = (ctrl_q[CTRL_CLEAR_MID] ? MID_SCALE_TAP : ZERO_SCALE_TAP)
                                ^ ((bipolar[g] && !codingS) ? CODE_MSB_MASK : 16'h0000);

            always_ff @(posedge core_clk)
            begin
                if (!rst_b)
                    inReg_q[g] <= DAC_RESET_CODE;
                else if (writeEnd && hit[g])
                    inReg_q[g] <= cmdData;
            end

            // clear outranks every update source
            always_ff @(posedge core_clk)
            begin
                if (!rst_b)
                    dac_q[g] <= DAC_RESET_CODE;
                else if (clearLvl)
                    dac_q[g] <= clearCode[g];
                else if (loadFall)
                    dac_q[g] <= (writeEnd && hit[g]) ? cmdData : inReg_q[g];
                else if (writeEnd && hit[g] && !loadS_n)
                    dac_q[g] <= cmdData;
            end

            dac_code_map u_map (
                .regCode      (dac_q[g]),
                .bipolar      (bipolar[g]),
                .offsetBinary (codingS),
                .tapCode      (tapD[g])
            );

            always_ff @(posedge core_clk)
            begin
                if (!rst_b)
                    tap_q[g] <= DAC_RESET_CODE;
                else
                    tap_q[g] <= tapD[g];
            end

            sequence s_writeHit;
                writeEnd && hit[g] && !clearLvl;
            endsequence

            sequence s_loadEdge;
                loadFall && !clearLvl;
            endsequence

            property p_inputLoad;
                (writeEnd && hit[g]) |=> inReg_q[g] == $past(cmdData);
            endproperty
            a_inputLoad: assert property (p_inputLoad) else $error("input register missed frame word");

            property p_shortFrame;
                (frameEnd && !wordOk) |=> $stable(inReg_q[g]);
            endproperty
            a_shortFrame: assert property (p_shortFrame) else $error("short frame changed a register");

            property p_tiedLow;
                s_writeHit ##0 !loadS_n |=> dac_q[g] == $past(cmdData);
            endproperty
            a_tiedLow: assert property (p_tiedLow) else $error("converter not updated at frame end");

            property p_heldOff;
                s_writeHit ##0 loadS_n |=> $stable(dac_q[g]) ##1 ($past(loadFall || clearLvl) || $stable(dac_q[g]));
            endproperty
            a_heldOff: assert property (p_heldOff) else $error("converter updated with strobe high");

            property p_loadAll;
                s_loadEdge |=> dac_q[g] == inReg_q[g];
            endproperty
            a_loadAll: assert property (p_loadAll) else $error("strobe edge did not copy input");

            property p_clearForce;
                clearLvl |=> dac_q[g] == $past(clearCode[g]);
            endproperty
            a_clearForce: assert property (p_clearForce) else $error("clear did not force the code");

            property p_resetZero;
                $rose(rst_b) |-> dac_q[g] == DAC_RESET_CODE;
            endproperty
            a_resetZero: assert property (p_resetZero) else $error("converter not zero after reset");

            property p_offsetBin;
                (bipolar[g] && codingS) |=> tap_q[g] == $past(dac_q[g]);
            endproperty
            a_offsetBin: assert property (p_offsetBin) else $error("offset binary mapping wrong");

            property p_twosComp;
                (bipolar[g] && !codingS) |=> tap_q[g] == ($past(dac_q[g]) ^ CODE_MSB_MASK);
            endproperty
            a_twosComp: assert property (p_twosComp) else $error("twos complement mapping wrong");

            property p_straight;
                !bipolar[g] |=> tap_q[g] == $past(dac_q[g]);
            endproperty
            a_straight: assert property (p_straight) else $error("unipolar mapping not straight");
        end
    endgenerate

    assign analog_output_first  = tap_q[0];
    assign analog_output_second = tap_q[1];

    // ahb-lite slave: zero wait states, write data taken in the data phase
    assign apValid   = hsel && (htrans == HTRANS_NONSEQ) && hready;
    assign hreadyout = 1'b1;
    assign hresp     = HRESP_OKAY;

    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            wrPend_q <= 1'b0;
            wrAddr_q <= '0;
        end
        else
        begin
            wrPend_q <= apValid && hwrite;
            wrAddr_q <= haddr[7:0];
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            ctrl_q <= CTRL_RESET;
        else if (wrPend_q && wrAddr_q == OFF_CTRL)
            ctrl_q <= hwdata[CTRL_BITS-1:0];
    end

    // only the low byte decodes, so the map repeats every 256 bytes
    always_comb
    begin
        rdMux = 32'h0000_0000;
        unique case (haddr[7:0])
            OFF_CTRL:     rdMux[CTRL_BITS-1:0] = ctrl_q;
            OFF_STATUS:
            begin
                rdMux[STAT_OVERSPEED] = overspeed_q;
                rdMux[STAT_FRAME]     = frameLow;
                rdMux[STAT_LOAD_LVL]  = loadS_n;
                rdMux[STAT_CLEAR]     = clearLvl;
                rdMux[STAT_CODING]    = codingS;
            end
            OFF_DAC_A:    rdMux[CODE_BITS-1:0] = dac_q[0];
            OFF_DAC_B:    rdMux[CODE_BITS-1:0] = dac_q[1];
            OFF_IN_A:     rdMux[CODE_BITS-1:0] = inReg_q[0];
            OFF_IN_B:     rdMux[CODE_BITS-1:0] = inReg_q[1];
            OFF_LAST_CMD: rdMux[WORD_BITS-1:0] = lastCmd_q;
            default:      rdMux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            rdata_q <= '0;
        else if (apValid && !hwrite)
            rdata_q <= rdMux;
    end

    assign hrdata = rdata_q;
endmodule // dac_link_core

/* bench/link_host_model.sv */
/*
  host side of the three-wire link: frames words onto the device pins and
  captures the stream coming back on the serial data output.
  assumes an 80 ns link period and a caller that runs one frame at a time.
*/
`timescale 1ns/1ps
module link_host_model (
    output logic      serialClk,
    output logic      frameSel_n,
    output logic      serial_data_in,
    input  wire logic serial_data_out
);
    logic [23:0] rxWord;

    initial
    begin
        serialClk      = 1'b1;
        frameSel_n     = 1'b1;
        serial_data_in = 1'b0;
        rxWord         = '0;
    end

    // clock stands high outside frames; 40 ns halves stay below 30 MHz
    task automatic send(input logic [31:0] w, input int n);
        frameSel_n <= 1'b0;
        for (int i = n - 1; i >= 0; i--)
        begin
            serial_data_in <= w[i];
            #40 serialClk <= 1'b0;
            rxWord <= {rxWord[22:0], serial_data_out};
            #40 serialClk <= 1'b1;
        end
        #40 frameSel_n <= 1'b1;
        // released line shows the inverse so a stale bit is never reused
        serial_data_in <= ~serial_data_in;
        #200;
    endtask

    // one clock pulse with the frame high: the device must ignore it
    task automatic idle_pulse();
        #40 serialClk <= 1'b0;
        #40 serialClk <= 1'b1;
        #200;
    endtask
endmodule // link_host_model

/* bench/dual_dac_serial_load_control_tb_top.sv */
/*
  self-checking bench for the serial converter front end: link frames from
  the host model, register access over AHB-Lite, load strobe and clear pins.
  assumes the slave answers with no wait states and hready loops back.
*/
`timescale 1ns/1ps
module dual_dac_serial_load_control_tb_top
    import dac_link_pkg::*;
;
    logic                 core_clk, rst_b, load_strobe_n, async_clear_n, coding_select;
    logic                 hsel, hwrite;
    logic [31:0]          haddr, hwdata, rdData;
    logic [1:0]           htrans;
    logic [2:0]           hsize;
    wire                  serialClk, frameSel_n, serial_data_in, serial_data_out;
    wire                  hready, hreadyout, hresp;
    wire  [31:0]          hrdata;
    wire  [CODE_BITS-1:0] outA, outB;
    int                   error_cnt, num_checks;

    assign hready = hreadyout;

    link_host_model link_host_model_i (.serialClk(serialClk), .frameSel_n(frameSel_n),
        .serial_data_in(serial_data_in), .serial_data_out(serial_data_out));

    dac_link_core dac_link_core_i (.core_clk(core_clk), .rst_b(rst_b), .serialClk(serialClk),
        .frameSel_n(frameSel_n), .serial_data_in(serial_data_in), .load_strobe_n(load_strobe_n),
        .async_clear_n(async_clear_n), .coding_select(coding_select),
        .serial_data_out(serial_data_out), .analog_output_first(outA), .analog_output_second(outB),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));

    always #2 core_clk = ~core_clk;

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // bounded wait for hready at a rising edge
    task automatic wait_ready();
        int i;
        for (i = 0; i < 16; i++)
        begin
            @(posedge core_clk);
            if (hready === 1'b1)
                break;
        end
        if (i == 16)
        begin
            error_cnt++;
            $display("[ERR] hready expected 1 seen timeout");
            wrap_up();
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr  <= {24'h0, a};
        hwrite <= wr;
        wait_ready();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
        rdData = hrdata;
        chk("hresp", {31'h0, hresp}, {31'h0, HRESP_OKAY});
    endtask

    function automatic logic [23:0] cmd(input logic rd, input logic [2:0] a, input logic [15:0] c);
        return {rd, 4'h0, a, c};
    endfunction

    // outputs land a handful of cycles after the synced frame end
    task automatic settle();
        repeat (20) @(posedge core_clk);
    endtask

    task automatic frame(input logic [31:0] w, input int n);
        link_host_model_i.send(w, n);
        settle();
    endtask

    initial
    begin
        core_clk = 0; rst_b = 0; load_strobe_n = 0; async_clear_n = 1; coding_select = 1;
        hsel = 0; hwrite = 0; haddr = '0; hwdata = '0; htrans = '0; hsize = 3'h2;
        error_cnt = 0; num_checks = 0;
        repeat (10) @(posedge core_clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge core_clk);
        bus(0, OFF_DAC_A, 0); chk("dacA", rdData, 0);
        bus(0, OFF_DAC_B, 0); chk("dacB", rdData, 0);
        chk("outA", outA, 0);
        $display("test reset done");

        frame(cmd(0, 3'h0, 16'h1234), 24);
        chk("outA", outA, 16'h1234);
        bus(0, OFF_DAC_A, 0); chk("dacA", rdData, 32'h1234);
        $display("test load low done");

        load_strobe_n <= 1'b1;
        frame(cmd(0, 3'h1, 16'habcd), 24);
        frame(cmd(0, 3'h0, 16'h5555), 24);
        bus(0, OFF_IN_B, 0); chk("inB", rdData, 32'habcd);
        chk("outB", outB, 0);
        chk("outA", outA, 16'h1234);
        load_strobe_n <= 1'b0;
        settle();
        chk("outA", outA, 16'h5555);
        chk("outB", outB, 16'habcd);
        $display("test deferred load done");

        frame({4'hf, cmd(0, 3'h0, 16'h0f0f)}, 28);
        chk("outA", outA, 16'h0f0f);
        frame(cmd(0, 3'h0, 16'h7777), 20);
        chk("outA", outA, 16'h0f0f);
        link_host_model_i.idle_pulse();
        settle();
        bus(0, OFF_LAST_CMD, 0); chk("lastCmd", rdData, {8'h0, cmd(0, 3'h0, 16'h0f0f)});
        $display("test frame length done");

        bus(1, OFF_CTRL, 32'h1);
        frame(cmd(0, ADDR_CHAN_ALL, 16'h2468), 24);
        chk("outA", outA, 16'h2468);
        chk("outB", outB, 16'h2468);
        // coding pin only moves under reset, never in operation
        rst_b         <= 1'b0;
        coding_select <= 1'b0;
        repeat (10) @(posedge core_clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge core_clk);
        chk("outA", outA, 0);
        bus(1, OFF_CTRL, 32'h1);
        frame(cmd(0, ADDR_CHAN_ALL, 16'h2468), 24);
        chk("outA", outA, 16'ha468);
        chk("outB", outB, 16'h2468);
        $display("test coding done");

        async_clear_n <= 1'b0;
        settle();
        chk("outA", outA, ZERO_SCALE_TAP);
        frame(cmd(0, ADDR_CHAN_ALL, 16'h1111), 24);
        chk("outB", outB, ZERO_SCALE_TAP);
        async_clear_n <= 1'b1;
        bus(1, OFF_CTRL, 32'h5);
        async_clear_n <= 1'b0;
        settle();
        chk("outA", outA, MID_SCALE_TAP);
        chk("outB", outB, MID_SCALE_TAP);
        async_clear_n <= 1'b1;
        $display("test clear done");

        bus(1, OFF_CTRL, 32'h8);
        frame(cmd(0, 3'h0, 16'h3c5a), 24);
        frame(cmd(1, 3'h0, 16'h0), 24);
        frame(cmd(0, 3'h7, 16'h0), 24);
        chk("readback", {8'h0, link_host_model_i.rxWord}, 32'h3c5a);
        $display("test readback done");

        bus(1, 8'h1c, 32'hffffffff);
        bus(0, 8'h1c, 0); chk("unmapped", rdData, 0);
        bus(0, OFF_CTRL, 0); chk("ctrl", rdData, 32'h8);
        bus(0, OFF_STATUS, 0); chk("status", rdData, 32'h0);
        $display("test registers done");
        wrap_up();
    end
endmodule // dual_dac_serial_load_control_tb_top
